// ### hdl/imrc_pkg.sv
package imrc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_TRANSCEIVER_IRQ_STATUS   = 6'h38;
  localparam logic [5:0] IDX_INTERRUPT_STATUS     = 6'h3c;
  localparam logic [5:0] IDX_MODE_CONFIG_ONE    = 6'h3d;
  localparam logic [5:0] IDX_MODE_CONFIG_TWO    = 6'h3e;
  localparam logic [5:0] IDX_ID       = 6'h3f;
  localparam int         ADR_W        = 8;

  localparam logic [7:0] MASK_RST     = 8'h7f;
  localparam logic [7:0] MODE_CONFIG_ONE_RST    = 8'h00;
  localparam logic [7:0] MODE_CONFIG_TWO_RST    = 8'h00;
  localparam logic [5:0] BLOCK_SOFT_RESET_RST     = 6'h00;

  // Interrupt status bit positions
  localparam int ST_BIT   = 6;
  localparam int CIC_BIT  = 5;
  localparam int TIN_BIT  = 4;
  localparam int WOV_BIT  = 3;
  localparam int TRAN_BIT = 2;
  localparam int MOS_BIT  = 1;
  localparam int HDLC_BIT = 0;

  // Transceiver interrupt status bits
  localparam int LD_BIT   = 3;
  localparam int RIC_BIT  = 2;

  // Mode one fields
  localparam int MCLK_HI  = 7;
  localparam int MCLK_LO  = 6;
  localparam int CDS_BIT  = 5;
  localparam int WATCHDOG_KICK_A_BIT = 4;
  localparam int WATCHDOG_KICK_B_BIT = 3;
  localparam int CFS_BIT  = 2;
  localparam int RSS_HI   = 1;
  localparam int RSS_LO   = 0;

  // Mode two fields
  localparam int DREF_BIT  = 2;
  localparam int SERIAL_OUT_PUSH_PULL_BIT = 0;

  // Soft reset bits, one per block
  localparam int BLOCK_SOFT_RESET_W = 6;
  localparam int CODEC_PLL_RESET_BIT = 5;
  localparam int RES_MON_BIT  = 4;
  localparam int RES_HDLC_BIT = 3;
  localparam int RES_IOM_BIT  = 2;
  localparam int RES_TR_BIT   = 1;
  localparam int RES_CO_BIT   = 0;

  localparam logic [1:0] RSS_NONE   = 2'h0;
  localparam logic [1:0] RSS_STROBE = 2'h1;
  localparam logic [1:0] RSS_AWAKE  = 2'h2;
  localparam logic [1:0] RSS_WDOG   = 2'h3;
  localparam logic [1:0] MCLK_OFF   = 2'h3;

  // Command codes on the downstream C/I channel; indication codes for power_ind_o
  localparam logic [3:0] CMD_TIM = 4'h0;
  localparam logic [3:0] CMD_AR  = 4'h8;
  localparam logic [3:0] CMD_DI  = 4'hf;
  localparam logic [3:0] IND_PD  = 4'hf;
  localparam logic [3:0] IND_PU  = 4'h7;

  // Timing
  localparam longint CLK_HZ       = 50_000_000;
  localparam longint WDOG_MS      = 128;
  localparam longint WDOG_CYC     = WDOG_MS * CLK_HZ / 1000;
  localparam longint RSTPULSE_US  = 125;
  localparam longint RSTPULSE_CYC = (RSTPULSE_US * CLK_HZ + 999_999) / 1_000_000;

  typedef enum logic [1:0] {
    PWR_DOWN,
    PWR_UP,
    PWR_ACTIVE
  } imrc_pwr_t;
endpackage

// ### hdl/imrc_top.sv
module imrc_top #(
  parameter logic [5:0] DESIGN_NUMBER = 6'h2a, // arbitrary value
  parameter int         WDOG_CYCLES   = int'(imrc_pkg::WDOG_CYC),
  parameter int         RST_CYCLES    = int'(imrc_pkg::RSTPULSE_CYC)
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [imrc_pkg::ADR_W-1:0] adr_i,
  input  wire logic [31:0]               dat_i,
  input  wire logic [3:0]                sel_i,
  output logic      [31:0]               dat_o,
  output logic                           ack_o,
  input  wire logic                      ci_change_i,
  input  wire logic                      ci0_down_change_i,
  input  wire logic                      ci_read_i,
  input  wire logic                      timer_expired_i,
  input  wire logic                      level_detect_i,
  input  wire logic                      receiver_change_i,
  input  wire logic                      monitor_change_i,
  input  wire logic                      monitor_read_i,
  input  wire logic                      hdlc_active_i,
  input  wire logic                      sync_transfer_i,
  input  wire logic                      sync_ack_i,
  input  wire logic                      terminal_functions_i,
  input  wire logic                      external_awake_i,
  input  wire logic                      undervoltage_i,
  input  wire logic                      serial_strobe_i,
  input  wire logic                      osc_en_i,
  input  wire logic                      cmd_valid_i,
  input  wire logic [3:0]                cmd_code_i,
  input  wire logic                      sw_powerup_i,
  input  wire logic                      serial_data_i,
  output logic                           irq_o,
  output logic                           mclk_en_o,
  output logic                           reset_out_n_o,
  output logic                           iom_clk_run_o,
  output logic      [3:0]                power_ind_o,
  output logic                           line_start_o,
  output logic                           serial_data_out_o,
  output logic                           serial_data_out_oe_o,
  output logic                           references_off_o,
  output logic      [imrc_pkg::BLOCK_SOFT_RESET_W-1:0] block_soft_reset_o
);

  if (WDOG_CYCLES < 2 || RST_CYCLES < 1) begin : g_chk
    $error("imrc_top: watchdog and reset pulse counts too small");
  end

  logic [7:0]       interrupt_mask;
  logic [7:0]       mode_config_one;
  logic [7:0]       mode_config_two;
  logic [6:0]       flags;
  logic             ric;
  logic [31:0]      wdog_cnt;
  logic             kick_armed;
  logic [31:0]      pulse_cnt;
  logic             pulse_from_ci;
  logic [3:0]       pre_cnt;
  imrc_pkg::imrc_pwr_t pwr;
  logic             cfs_q;

  logic             req;
  logic             wr;
  logic             rd;
  logic             hit_transceiver_irq_status;
  logic             hit_interrupt_status;
  logic             hit_mode_config_one;
  logic             hit_mode_config_two;
  logic             hit_id;
  logic [6:0]       visible;
  logic [7:0]       transceiver_irq_status_val;
  logic [1:0]       reset_source_select;
  logic             wdog_on;
  logic             wdog_expire;
  logic             awake_trig;
  logic             pulse_on;
  logic             pulse_end;
  logic [3:0]       pre_div;
  logic             config_select_power;

  // Accept each request once; ack follows one cycle later
  assign req        = cyc_i && stb_i && !ack_o;
  assign wr         = req && we_i && sel_i[0];
  assign rd         = req && !we_i;
  assign hit_transceiver_irq_status = adr_i == {imrc_pkg::IDX_TRANSCEIVER_IRQ_STATUS, 2'b00};
  assign hit_interrupt_status   = adr_i == {imrc_pkg::IDX_INTERRUPT_STATUS, 2'b00};
  assign hit_mode_config_one  = adr_i == {imrc_pkg::IDX_MODE_CONFIG_ONE, 2'b00};
  assign hit_mode_config_two  = adr_i == {imrc_pkg::IDX_MODE_CONFIG_TWO, 2'b00};
  assign hit_id     = adr_i == {imrc_pkg::IDX_ID, 2'b00};

  assign visible    = flags & ~interrupt_mask[6:0];
  assign transceiver_irq_status_val = {4'h0, level_detect_i, ric, 2'b00};
  assign reset_source_select        = mode_config_one[imrc_pkg::RSS_HI:imrc_pkg::RSS_LO];
  assign config_select_power        = mode_config_one[imrc_pkg::CFS_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      if (hit_interrupt_status) begin
        dat_o <= {25'h0, visible};
      end else if (hit_mode_config_one) begin
        dat_o <= {24'h0, mode_config_one};
      end else if (hit_mode_config_two) begin
        dat_o <= {24'h0, mode_config_two};
      end else if (hit_id) begin
        dat_o <= {26'h0, DESIGN_NUMBER};
      end else if (hit_transceiver_irq_status) begin
        dat_o <= {24'h0, transceiver_irq_status_val};
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_mask <= imrc_pkg::MASK_RST;
    end else if (wr && hit_interrupt_status) begin
      interrupt_mask <= {1'b0, dat_i[6:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_config_one <= imrc_pkg::MODE_CONFIG_ONE_RST;
    end else if (wr && hit_mode_config_one) begin
      mode_config_one <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_config_two <= imrc_pkg::MODE_CONFIG_TWO_RST;
    end else if (wr && hit_mode_config_two) begin
      mode_config_two <= {5'h00, dat_i[imrc_pkg::DREF_BIT], 1'b0, dat_i[imrc_pkg::SERIAL_OUT_PUSH_PULL_BIT]};
    end
  end

  // Write at the identity address lands in the soft reset bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_soft_reset_o <= imrc_pkg::BLOCK_SOFT_RESET_RST;
    end else if (wr && hit_id) begin
      block_soft_reset_o <= dat_i[imrc_pkg::BLOCK_SOFT_RESET_W-1:0];
    end
  end

  // Receiver change: set wins over the clearing read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ric <= 1'b0;
    end else if (receiver_change_i) begin
      ric <= 1'b1;
    end else if (rd && hit_transceiver_irq_status) begin
      ric <= 1'b0;
    end
  end

  // Sticky flags except TRAN and HDLC, which follow their sources each cycle; a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= 7'h00;
    end else begin
      if (sync_transfer_i) begin
        flags[imrc_pkg::ST_BIT] <= 1'b1;
      end else if (sync_ack_i) begin
        flags[imrc_pkg::ST_BIT] <= 1'b0;
      end
      if (ci_change_i || (pulse_end && pulse_from_ci)) begin
        flags[imrc_pkg::CIC_BIT] <= 1'b1;
      end else if (ci_read_i) begin
        flags[imrc_pkg::CIC_BIT] <= 1'b0;
      end
      if (timer_expired_i) begin
        flags[imrc_pkg::TIN_BIT] <= 1'b1;
      end else if (rd && hit_interrupt_status && visible[imrc_pkg::TIN_BIT]) begin
        flags[imrc_pkg::TIN_BIT] <= 1'b0;
      end
      if (wdog_expire) begin
        flags[imrc_pkg::WOV_BIT] <= 1'b1;
      end else if (rd && hit_interrupt_status && visible[imrc_pkg::WOV_BIT]) begin
        flags[imrc_pkg::WOV_BIT] <= 1'b0;
      end
      flags[imrc_pkg::TRAN_BIT] <= level_detect_i || ric;
      if (monitor_change_i) begin
        flags[imrc_pkg::MOS_BIT] <= 1'b1;
      end else if (monitor_read_i) begin
        flags[imrc_pkg::MOS_BIT] <= 1'b0;
      end
      flags[imrc_pkg::HDLC_BIT] <= hdlc_active_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |visible;
    end
  end

  // Watchdog runs only in reset-source mode 11 with terminal functions
  assign wdog_on     = (reset_source_select == imrc_pkg::RSS_WDOG) && terminal_functions_i;
  assign wdog_expire = wdog_on && (wdog_cnt == 32'(WDOG_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kick_armed <= 1'b0;
    end else if (!wdog_on || wdog_expire) begin
      kick_armed <= 1'b0;
    end else if (wr && hit_mode_config_one) begin
      kick_armed <= dat_i[imrc_pkg::WATCHDOG_KICK_A_BIT] && !dat_i[imrc_pkg::WATCHDOG_KICK_B_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_cnt <= 32'h0000_0000;
    end else if (!wdog_on || wdog_expire) begin
      wdog_cnt <= 32'h0000_0000;
    end else if (wr && hit_mode_config_one && kick_armed && !dat_i[imrc_pkg::WATCHDOG_KICK_A_BIT]
                 && dat_i[imrc_pkg::WATCHDOG_KICK_B_BIT]) begin
      wdog_cnt <= 32'h0000_0000;
    end else begin
      wdog_cnt <= wdog_cnt + 32'h0000_0001;
    end
  end

  // Reset pulse of fixed length; retriggers are ignored while it runs
  assign awake_trig = (reset_source_select == imrc_pkg::RSS_AWAKE) && (external_awake_i || ci0_down_change_i);
  assign pulse_on   = pulse_cnt != 32'h0000_0000;
  assign pulse_end  = pulse_cnt == 32'h0000_0001;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_cnt <= 32'h0000_0000;
    end else if (!pulse_on && (awake_trig || wdog_expire)) begin
      pulse_cnt <= 32'(RST_CYCLES);
    end else if (pulse_on) begin
      pulse_cnt <= pulse_cnt - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_from_ci <= 1'b0;
    end else if (!pulse_on && (awake_trig || wdog_expire)) begin
      pulse_from_ci <= awake_trig;
    end
  end

  // Pin shows strobe only in mode 01; hardware and undervoltage always win
  always_ff @(posedge clk_i) begin
    if (rst_i || undervoltage_i) begin
      reset_out_n_o <= 1'b0;
    end else begin
      unique case (reset_source_select)
        imrc_pkg::RSS_NONE:   reset_out_n_o <= 1'b1;
        imrc_pkg::RSS_STROBE: reset_out_n_o <= serial_strobe_i;
        imrc_pkg::RSS_AWAKE,
        imrc_pkg::RSS_WDOG:   reset_out_n_o <= !pulse_on;
      endcase
    end
  end

  // Controller clock prescaler counts oscillator enables
  always_comb begin
    unique case (mode_config_one[imrc_pkg::MCLK_HI:imrc_pkg::MCLK_LO])
      2'h0:    pre_div = 4'h2;
      2'h1:    pre_div = 4'h8;
      2'h2:    pre_div = 4'h1;
      default: pre_div = 4'h1;
    endcase
    if (!mode_config_one[imrc_pkg::CDS_BIT]) begin
      pre_div = {pre_div[2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt   <= 4'h0;
      mclk_en_o <= 1'b0;
    end else if (mode_config_one[imrc_pkg::MCLK_HI:imrc_pkg::MCLK_LO] == imrc_pkg::MCLK_OFF) begin
      pre_cnt   <= 4'h0;
      mclk_en_o <= 1'b0;
    end else if (osc_en_i) begin
      mclk_en_o <= pre_cnt >= pre_div - 4'h1;
      pre_cnt   <= (pre_cnt >= pre_div - 4'h1) ? 4'h0 : pre_cnt + 4'h1;
    end else begin
      mclk_en_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfs_q <= 1'b0;
    end else begin
      cfs_q <= config_select_power;
    end
  end

  // Power state; reset lands in power down with clocks still running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr          <= imrc_pkg::PWR_DOWN;
      line_start_o <= 1'b0;
    end else begin
      line_start_o <= 1'b0;
      if (cmd_valid_i && cmd_code_i == imrc_pkg::CMD_DI) begin
        pwr <= imrc_pkg::PWR_DOWN;
      end else if (cmd_valid_i && cmd_code_i == imrc_pkg::CMD_AR
                   && (!config_select_power || pwr != imrc_pkg::PWR_DOWN)) begin
        pwr          <= imrc_pkg::PWR_ACTIVE;
        line_start_o <= 1'b1;
      end else if (pwr == imrc_pkg::PWR_DOWN) begin
        if (!config_select_power && cmd_valid_i && cmd_code_i == imrc_pkg::CMD_TIM) begin
          pwr <= imrc_pkg::PWR_UP;
        end else if (config_select_power && sw_powerup_i) begin
          pwr <= imrc_pkg::PWR_UP;
        end else if (cfs_q && !config_select_power) begin
          pwr <= imrc_pkg::PWR_UP;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iom_clk_run_o <= 1'b1;
      power_ind_o   <= imrc_pkg::IND_PD;
    end else begin
      iom_clk_run_o <= !config_select_power || pwr != imrc_pkg::PWR_DOWN;
      power_ind_o   <= (pwr == imrc_pkg::PWR_DOWN) ? imrc_pkg::IND_PD
                                                   : imrc_pkg::IND_PU;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_data_out_o    <= 1'b0;
      serial_data_out_oe_o <= 1'b0;
      references_off_o     <= 1'b0;
    end else begin
      references_off_o <= mode_config_two[imrc_pkg::DREF_BIT];
      if (mode_config_two[imrc_pkg::SERIAL_OUT_PUSH_PULL_BIT]) begin
        serial_data_out_o    <= serial_data_i;
        serial_data_out_oe_o <= 1'b1;
      end else begin
        serial_data_out_o    <= 1'b0;
        serial_data_out_oe_o <= !serial_data_i;
      end
    end
  end

endmodule

// ### dv/imrc_assertions.sv
module imrc_assertions #(
  parameter logic [5:0] DESIGN_NUMBER = 6'h2a // arbitrary value
) (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        cyc_i,
  input wire logic                        stb_i,
  input wire logic                        we_i,
  input wire logic [imrc_pkg::ADR_W-1:0]  adr_i,
  input wire logic [31:0]                 dat_i,
  input wire logic [3:0]                  sel_i,
  input wire logic [31:0]                 dat_o,
  input wire logic                        ack_o,
  input wire logic                        undervoltage_i,
  input wire logic                        cmd_valid_i,
  input wire logic [3:0]                  cmd_code_i,
  input wire logic                        reset_out_n_o,
  input wire logic [3:0]                  power_ind_o,
  input wire logic [imrc_pkg::BLOCK_SOFT_RESET_W-1:0] block_soft_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_next;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_rd_hi;
    ack_o && !we_i |-> dat_o[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_id;
    ack_o && !we_i && adr_i == 8'hfc |-> dat_o[7:0] == {2'b00, DESIGN_NUMBER};
  endproperty
  a_id: assert property (p_id) else $error("identity wrong");
  property p_block_soft_reset;
    cyc_i && stb_i && !ack_o && we_i && sel_i[0] && adr_i == 8'hfc
      |=> block_soft_reset_o == $past(dat_i[5:0]);
  endproperty
  a_block_soft_reset: assert property (p_block_soft_reset) else $error("soft reset bits wrong");
  property p_uv;
    $rose(undervoltage_i) |-> ##[1:2] !reset_out_n_o;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not on pin");
  property p_di;
    cmd_valid_i && cmd_code_i == 4'hf |-> ##[1:3] power_ind_o == 4'hf;
  endproperty
  a_di: assert property (p_di) else $error("no power down");
  property p_code;
    power_ind_o == 4'hf || power_ind_o == 4'h7;
  endproperty
  a_code: assert property (p_code) else $error("bad power code");
endmodule

bind imrc_top imrc_assertions #(.DESIGN_NUMBER(DESIGN_NUMBER)) u_chk (.*);

// ### dv/irq_mode_reset_control_bench.sv
module irq_mode_reset_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
`define W(x) begin k = 0; num_checks++; while ((x) !== 1'b1 && k < 400) begin \
  @(posedge clk_i); k++; end if (k >= 400) begin n_mismatch++; \
  $display("Error wait expected 1 seen 0"); print_verdict; end end
`define P(s) begin @(posedge clk_i); s <= 1'b1; @(posedge clk_i); s <= 1'b0; end
`define C(v) begin cmd_code_i <= v; `P(cmd_valid_i) end
  logic clk_i = '0, rst_i = 1'b1, cyc_i = '0, stb_i = '0, we_i = '0, osc_en_i = '0;
  logic [7:0]  adr_i = '0;
  logic [31:0] dat_i = '0;
  logic [3:0]  sel_i = 4'hf, cmd_code_i = '0;
  logic ci_change_i = '0, ci0_down_change_i = '0, ci_read_i = '0, timer_expired_i = '0;
  logic level_detect_i = '0, receiver_change_i = '0, monitor_change_i = '0;
  logic monitor_read_i = '0, hdlc_active_i = '0, sync_transfer_i = '0, sync_ack_i = '0;
  logic terminal_functions_i = '0, external_awake_i = '0, undervoltage_i = '0;
  logic serial_strobe_i = '0, cmd_valid_i = '0, sw_powerup_i = '0, serial_data_i = '0;
  logic [31:0] dat_o, rd;
  logic ack_o, irq_o, mclk_en_o, reset_out_n_o, iom_clk_run_o, line_start_o;
  logic serial_data_out_o, serial_data_out_oe_o, references_off_o;
  logic [3:0]  power_ind_o;
  logic [5:0]  block_soft_reset_o;
  int n_mismatch = 0, num_checks = 0, k, c, j, oc = 0;
  logic [7:0]  mt [6] = '{8'h20, 8'h60, 8'ha0, 8'h00, 8'h40, 8'h80};
  int          dv [6] = '{2, 8, 1, 4, 16, 2};

  imrc_top #(.WDOG_CYCLES(200), .RST_CYCLES(10)) i_dut (.*);

  always #10 clk_i = ~clk_i;
  // Roughly 16.67 MHz against 50 MHz; fixed spacing keeps periods exact
  always @(posedge clk_i) begin
    oc <= (oc == 2) ? 0 : oc + 1;
    osc_en_i <= (oc == 2);
  end

  task automatic print_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    `W(ack_o)
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK("read data", {24'h0, e}, rd)
  endtask

  task automatic low_len;
    `W(!reset_out_n_o)
    c = 0;
    while (reset_out_n_o !== 1'b1 && c < 400) begin
      @(posedge clk_i);
      c++;
    end
    `CHK("reset pulse", 10, c)
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("iom run", 1'b1, iom_clk_run_o)
    `CHK("power ind", 4'hf, power_ind_o)
    rdc(8'hf4, 8'h00);
    rdc(8'hf8, 8'h00);
    rdc(8'hfc, 8'h2a);
    wb(1'b1, 8'hfc, 8'h3f);
    `CHK("soft reset", 6'h3f, block_soft_reset_o)
    rdc(8'hfc, 8'h2a);
    wb(1'b1, 8'hfc, 8'h00);
    wb(1'b1, 8'hf8, 8'h04);
    rdc(8'hf8, 8'h04);
    `CHK("refs off", 1'b1, references_off_o)
    wb(1'b1, 8'hf8, 8'h00);
    wb(1'b1, 8'h00, 8'hff);
    rdc(8'h00, 8'h00);
    // Reset mask hides everything
    `P(timer_expired_i)
    rdc(8'hf0, 8'h00);
    `CHK("irq", 1'b0, irq_o)
    wb(1'b1, 8'hf0, 8'h00);
    rdc(8'hf0, 8'h10);
    rdc(8'hf0, 8'h00);
    `P(timer_expired_i)
    `W(irq_o)
    rdc(8'hf0, 8'h10);
    wb(1'b1, 8'hf0, 8'h20);
    `P(ci_change_i)
    repeat (3) @(posedge clk_i);
    `CHK("irq", 1'b0, irq_o)
    wb(1'b1, 8'hf0, 8'h00);
    rdc(8'hf0, 8'h20);
    rdc(8'hf0, 8'h20);
    `P(ci_read_i)
    rdc(8'hf0, 8'h00);
    `P(sync_transfer_i)
    rdc(8'hf0, 8'h40);
    `P(sync_ack_i)
    rdc(8'hf0, 8'h00);
    `P(monitor_change_i)
    rdc(8'hf0, 8'h02);
    `P(monitor_read_i)
    rdc(8'hf0, 8'h00);
    `P(receiver_change_i)
    rdc(8'hf0, 8'h04);
    rdc(8'he0, 8'h04);
    rdc(8'hf0, 8'h00);
    level_detect_i <= 1'b1;
    rdc(8'hf0, 8'h04);
    level_detect_i <= 1'b0;
    hdlc_active_i <= 1'b1;
    rdc(8'hf0, 8'h01);
    hdlc_active_i <= 1'b0;
    rdc(8'hf0, 8'h00);
    for (j = 0; j < 6; j++) begin
      wb(1'b1, 8'hf4, mt[j]);
      `W(mclk_en_o)
      // First period after a change may be short, so measure the second
      repeat (2) begin
        c = 0;
        do begin
          @(posedge clk_i);
          c++;
        end while (mclk_en_o !== 1'b1 && c < 99);
      end
      `CHK("mclk period", dv[j] * 3, c)
    end
    wb(1'b1, 8'hf4, 8'hc0);
    repeat (3) @(posedge clk_i);
    c = 0;
    repeat (60) begin
      @(posedge clk_i);
      c += (mclk_en_o !== 1'b0);
    end
    `CHK("mclk off", 0, c)
    terminal_functions_i <= 1'b1;
    wb(1'b1, 8'hf4, 8'h03);
    for (j = 0; j < 4; j++) begin
      wb(1'b1, 8'hf4, 8'h13);
      wb(1'b1, 8'hf4, 8'h0b);
      repeat (100) @(posedge clk_i);
      `CHK("reset pin", 1'b1, reset_out_n_o)
    end
    low_len;
    rdc(8'hf0, 8'h08);
    rdc(8'hf0, 8'h00);
    wb(1'b1, 8'hf4, 8'h02);
    for (j = 0; j < 2; j++) begin
      if (j == 0) `P(external_awake_i)
      else `P(ci0_down_change_i)
      low_len;
      rdc(8'hf0, 8'h20);
      `P(ci_read_i)
    end
    wb(1'b1, 8'hf4, 8'h00);
    undervoltage_i <= 1'b1;
    `W(!reset_out_n_o)
    undervoltage_i <= 1'b0;
    `W(reset_out_n_o)
    `C(4'h0)
    `W(power_ind_o == 4'h7)
    `C(4'hf)
    `W(power_ind_o == 4'hf)
    `C(4'h8)
    `W(line_start_o)
    `W(power_ind_o == 4'h7)
    `C(4'hf)
    `W(power_ind_o == 4'hf)
    `CHK("iom run", 1'b1, iom_clk_run_o)
    wb(1'b1, 8'hf4, 8'h04);
    `W(!iom_clk_run_o)
    `P(sw_powerup_i)
    `W(iom_clk_run_o && power_ind_o == 4'h7)
    `C(4'hf)
    `W(!iom_clk_run_o)
    wb(1'b1, 8'hf4, 8'h00);
    `W(iom_clk_run_o && power_ind_o == 4'h7)
    `W(!serial_data_out_o && serial_data_out_oe_o)
    serial_data_i <= 1'b1;
    `W(!serial_data_out_oe_o)
    wb(1'b1, 8'hf8, 8'h01);
    `W(serial_data_out_o && serial_data_out_oe_o)
    print_verdict;
  end
endmodule
